// ===== pkg/cbt_params.svh
// Purpose: named constants for the compare-branch / predication / table-jump unit
// Assumes: 32-bit program counter, condition codes in the usual 4-bit encoding
// Notes:   definitions only, included by bare name
//
// Overview of operation
// - zero test branches when operand equals zero
// - nonzero test branches when operand is nonzero
// - compare operand limited to registers 0..7; the code does not check base_sel and tests base_val from any register
// - compare target is 4 to 130 bytes ahead
// - prefix makes up to four following ops conditional
// - then keeps condition, else inverts it
// - always prefix: every slot unconditional, never else
// - breakpoint in block always executes
// - exceptions save block state for recovery
// - exception return resumes interrupted block
// - prefix and table jumps keep flags unchanged
// - table offset is twice unsigned entry
// - halfword index shifted left by one
// - table target is next address plus offset
// - pc base means table follows instruction
`ifndef CBT_PARAMS_SVH
`define CBT_PARAMS_SVH

`define CBT_COND_ALWAYS 4'hE
`define CBT_PC_SEL      4'hF
`define CBT_CB_AHEAD    32'h0000_0004
`define CBT_TBL_LEN     32'h0000_0004
`define CBT_CB_MIN      32'h0000_0004
`define CBT_CB_MAX      32'h0000_0082
`define CBT_SLOTS       4

`endif

// ===== pkg/cbt_pkg.sv
// Purpose: shared types of the control-flow unit
// Assumes: kind codes come from the upstream decoder
// Notes:   code 3'b111 is unused and treated as an ordinary op
package cbt_pkg;

  // decoded instruction class
  typedef enum logic [2:0] {
    KIND_OTHER   = 3'b000,
    KIND_ZERO    = 3'b001,
    KIND_NONZERO = 3'b010,
    KIND_PREFIX  = 3'b011,
    KIND_BYTE    = 3'b100,
    KIND_HALF    = 3'b101,
    KIND_BREAK   = 3'b110
  } cbt_kind_type;

  // table fetch sequencer
  typedef enum logic {
    TBL_IDLE = 1'b0,
    TBL_WAIT = 1'b1
  } cbt_tbl_type;

  // predication state: bit 0 of inv/live is the current slot
  typedef struct packed {
    logic [3:0] cond;
    logic [3:0] inv;
    logic [3:0] live;
  } cbt_pred_type;

endpackage : cbt_pkg

// ===== pkg/cbt_cond_if.sv
// Purpose: carries a condition query between the unit and its evaluator
// Assumes: purely combinational answer
// Notes:   flags ordered n, z, c, v from bit 3 down
`timescale 1ns/100ps
interface cbt_cond_if;
  logic [3:0] cond;   // condition code asked about
  logic [3:0] flags;  // current nzcv
  logic       pass;   // condition holds

  modport user (output cond, output flags, input pass);
  modport eval (input cond, input flags, output pass);
endinterface : cbt_cond_if

// ===== src/cbt_cond_eval.sv
// Purpose: evaluate a 4-bit condition code against nzcv
// Assumes: odd codes are the inverse of the even code below them
// Notes:   code 4'hF is treated as always as well
`timescale 1ns/100ps
module cbt_cond_eval (
  cbt_cond_if.eval cif  // query and answer
);
  logic n;    // negative
  logic z;    // zero
  logic c;    // carry
  logic v;    // overflow
  logic base; // even-code result

  assign {n, z, c, v} = cif.flags;

  // pair evaluation, low bit inverts except for always
  always_comb
  begin
    unique case (cif.cond[3:1])
      3'b000: base = z;
      3'b001: base = c;
      3'b010: base = n;
      3'b011: base = v;
      3'b100: base = c & ~z;
      3'b101: base = (n == v);
      3'b110: base = ~z & (n == v);
      3'b111: base = 1'b1;
    endcase
    cif.pass = (cif.cond[3:1] == 3'b111) ? 1'b1 : (base ^ cif.cond[0]);
  end
endmodule : cbt_cond_eval

// ===== src/cbt_ctrl_flow.sv
// Purpose: execute compare branches, the predication prefix and table jumps
// Assumes: one instruction offered per valid cycle, register values pre-read
// Notes:   table jumps stall through busy_q until the table entry arrives
`timescale 1ns/100ps
`include "cbt_params.svh"
module cbt_ctrl_flow #(
  parameter int DW = 32                     // address and data width
) (
  input  wire logic                 ref_clk,     // core clock
  input  wire logic                 nrst,        // sync reset, low
  input  wire logic                 ins_valid,   // instruction offered
  input  wire cbt_pkg::cbt_kind_type ins_kind,   // decoded class
  input  wire logic [DW-1:0]        ins_pc,      // instruction address
  input  wire logic [6:0]           cb_offset,   // compare branch offset, even
  input  wire logic [3:0]           base_sel,    // base register number
  input  wire logic [DW-1:0]        base_val,    // base register value
  input  wire logic [DW-1:0]        index_val,   // index register value
  input  wire logic [3:0]           pfx_cond,    // prefix first condition
  input  wire logic [2:0]           pfx_len,     // prefix slots, 1 to 4
  input  wire logic [2:0]           pfx_else,    // else letters, slots 2..4
  input  wire logic [3:0]           flags_nzcv,  // current flags
  input  wire logic                 mem_ack,     // table entry returned
  input  wire logic [15:0]          mem_rdata,   // table entry
  input  wire logic                 exc_entry,   // exception taken
  input  wire logic                 exc_return,  // exception return
  input  wire cbt_pkg::cbt_pred_type exc_restore, // state from the stacked copy
  output      logic                 busy_q,      // not accepting
  output      logic                 ins_exec_q,  // op executed, not skipped
  output      logic                 flags_keep_q,// op leaves flags alone
  output      logic                 br_take_q,   // branch pulse
  output      logic [DW-1:0]        br_target_q, // branch address
  output      logic                 mem_req_q,   // table read request
  output      logic [DW-1:0]        mem_addr_q,  // table entry address
  output      logic                 mem_half_q,  // halfword entry
  output      cbt_pkg::cbt_pred_type pred_q,     // live predication state
  output      cbt_pkg::cbt_pred_type exc_saved_q // state for stacking
);

  cbt_pkg::cbt_tbl_type  state_q, state_d;   // table sequencer
  cbt_pkg::cbt_pred_type pred_d, saved_d;    // predication next values
  logic                  exec_d, keep_d, take_d, req_d, half_d;
  logic [DW-1:0]         target_d, addr_d;
  logic [DW-1:0]         next_q, next_d;     // address after table jump
  logic                  in_blk;             // a slot is pending
  logic                  slot_ok;            // current slot may execute
  logic [3:0]            pfx_live, pfx_inv;  // decoded prefix slots
  logic                  pfx_always;         // prefix uses always code
  logic                  adv;                // retire one slot
  logic                  fire;               // instruction accepted
  logic [DW-1:0]         tbl_base, tbl_idx;  // table address parts

  cbt_cond_if cif ();

  cbt_cond_eval cbt_cond_eval_inst (
    .cif (cif)
  );

  assign in_blk = |pred_q.live;
  assign cif.cond  = pred_q.cond ^ {3'b000, pred_q.inv[0]};
  assign cif.flags = flags_nzcv;
  assign slot_ok   = !in_blk || cif.pass || (ins_kind == cbt_pkg::KIND_BREAK);
  assign fire      = ins_valid && !busy_q && !exc_entry && !exc_return;
  assign pfx_always = (pfx_cond == `CBT_COND_ALWAYS);

  // always prefix never inverts a slot
  genvar k;
  generate
    for (k = 0; k < `CBT_SLOTS; k++)
    begin : g_slot
      assign pfx_live[k] = (32'(pfx_len) > k);
      if (k == 0)
      begin : g_first
        assign pfx_inv[k] = 1'b0;
      end
      else
      begin : g_rest
        assign pfx_inv[k] = pfx_else[k-1] && !pfx_always && pfx_live[k];
      end
    end
  endgenerate

  // pc base points just past the table jump
  assign tbl_base = (base_sel == `CBT_PC_SEL) ? ins_pc + `CBT_TBL_LEN : base_val;
  assign tbl_idx  = (ins_kind == cbt_pkg::KIND_HALF) ? {index_val[DW-2:0], 1'b0}
                                                     : index_val;

  // next-state logic for sequencer, predication and outputs
  always_comb
  begin
    state_d  = state_q;
    pred_d   = pred_q;
    saved_d  = exc_saved_q;
    exec_d   = 1'b0;
    keep_d   = 1'b0;
    take_d   = 1'b0;
    req_d    = mem_req_q;
    half_d   = mem_half_q;
    target_d = br_target_q;
    addr_d   = mem_addr_q;
    next_d   = next_q;
    adv      = 1'b0;
    if (exc_entry)
    begin
      // stack the block state, handler runs unpredicated
      saved_d = pred_q;
      pred_d  = '0;
      state_d = cbt_pkg::TBL_IDLE;
      req_d   = 1'b0;
    end
    else if (exc_return)
    begin
      pred_d  = exc_restore;
      state_d = cbt_pkg::TBL_IDLE;
      req_d   = 1'b0;
    end
    else if (state_q == cbt_pkg::TBL_WAIT)
    begin
      if (mem_ack)
      begin
        // offset is twice the unsigned entry
        // relative to the byte after the instruction
        target_d = mem_half_q ? next_q + DW'({mem_rdata, 1'b0})
                              : next_q + DW'({mem_rdata[7:0], 1'b0});
        take_d   = 1'b1;
        exec_d   = 1'b1;
        keep_d   = 1'b1;
        req_d    = 1'b0;
        state_d  = cbt_pkg::TBL_IDLE;
        adv      = in_blk;
      end
    end
    else if (fire)
    begin
      exec_d = slot_ok;
      adv    = in_blk;
      unique case (ins_kind)
        cbt_pkg::KIND_ZERO, cbt_pkg::KIND_NONZERO:
        begin
          // base_val tested whatever base_sel holds, flags kept
          // target four bytes ahead plus even offset
          take_d   = slot_ok && ((base_val == '0) ^ (ins_kind == cbt_pkg::KIND_NONZERO));
          target_d = ins_pc + `CBT_CB_AHEAD + DW'(cb_offset);
          keep_d   = 1'b1;
        end
        cbt_pkg::KIND_PREFIX:
        begin
          // load condition and up to four slots
          pred_d.cond = pfx_cond;
          pred_d.inv  = pfx_inv;
          pred_d.live = pfx_live;
          keep_d      = 1'b1;
          adv         = 1'b0;
        end
        cbt_pkg::KIND_BYTE, cbt_pkg::KIND_HALF:
        begin
          keep_d = 1'b1;
          if (slot_ok)
          begin
            state_d = cbt_pkg::TBL_WAIT;
            req_d   = 1'b1;
            half_d  = (ins_kind == cbt_pkg::KIND_HALF);
            addr_d  = tbl_base + tbl_idx;
            next_d  = ins_pc + `CBT_TBL_LEN;
            exec_d  = 1'b0;
            adv     = 1'b0;
          end
        end
        cbt_pkg::KIND_OTHER, cbt_pkg::KIND_BREAK:
        begin
          keep_d = 1'b0;
        end
        default:
        begin
          keep_d = 1'b0;
        end
      endcase
    end
    // retire the slot, clear after the last one
    if (adv)
    begin
      pred_d.inv  = pred_q.inv >> 1;
      pred_d.live = pred_q.live >> 1;
      if (pred_q.live[3:1] == 3'b000)
      begin
        pred_d.cond = 4'h0;
      end
    end
  end

  // registers only
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state_q      <= cbt_pkg::TBL_IDLE;
      pred_q       <= '0;
      exc_saved_q  <= '0;
      ins_exec_q   <= 1'b0;
      flags_keep_q <= 1'b0;
      br_take_q    <= 1'b0;
      br_target_q  <= '0;
      mem_req_q    <= 1'b0;
      mem_half_q   <= 1'b0;
      mem_addr_q   <= '0;
      next_q       <= '0;
      busy_q       <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      pred_q       <= pred_d;
      exc_saved_q  <= saved_d;
      ins_exec_q   <= exec_d;
      flags_keep_q <= keep_d;
      br_take_q    <= take_d;
      br_target_q  <= target_d;
      mem_req_q    <= req_d;
      mem_half_q   <= half_d;
      mem_addr_q   <= addr_d;
      next_q       <= next_d;
      busy_q       <= (state_d == cbt_pkg::TBL_WAIT);
    end
  end

  default clocking cb_clk @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // checks beside the logic above
  chk_zero_take: assert property (
    fire && !in_blk && ins_kind == cbt_pkg::KIND_ZERO && base_val == '0
    |=> br_take_q && br_target_q == $past(ins_pc) + `CBT_CB_AHEAD + DW'($past(cb_offset)))
    else $error("zero test did not branch");
  chk_nonzero_skip: assert property (
    fire && ins_kind == cbt_pkg::KIND_NONZERO && base_val == '0 |=> !br_take_q)
    else $error("nonzero test branched on zero");
  chk_cb_range: assert property (
    fire && ins_kind == cbt_pkg::KIND_ZERO |=> (br_target_q - $past(ins_pc)) >= `CBT_CB_MIN
      && (br_target_q - $past(ins_pc)) <= `CBT_CB_MAX)
    else $error("compare branch target out of range");
  chk_pfx_load: assert property (
    fire && ins_kind == cbt_pkg::KIND_PREFIX && pfx_len == 3'h4
    |=> pred_q.live == 4'hF && pred_q.cond == $past(pfx_cond))
    else $error("prefix did not open four slots");
  chk_always_noinv: assert property (
    pred_q.cond == `CBT_COND_ALWAYS |-> pred_q.inv == 4'h0)
    else $error("always block has an inverted slot");
  chk_brk_exec: assert property (
    fire && in_blk && ins_kind == cbt_pkg::KIND_BREAK |=> ins_exec_q)
    else $error("breakpoint skipped in block");
  chk_exc_save: assert property (
    exc_entry |=> exc_saved_q == $past(pred_q) && pred_q.live == 4'h0)
    else $error("block state not saved on entry");
  chk_exc_resume: assert property (
    !exc_entry && exc_return |=> pred_q == $past(exc_restore))
    else $error("block state not restored");
  chk_flags_keep: assert property (
    fire && ins_kind == cbt_pkg::KIND_PREFIX |=> flags_keep_q)
    else $error("prefix may touch flags");
  chk_half_addr: assert property (
    fire && !in_blk && ins_kind == cbt_pkg::KIND_HALF && base_sel != `CBT_PC_SEL
    |=> mem_req_q && mem_addr_q == $past(base_val) + {$past(index_val[DW-2:0]), 1'b0})
    else $error("halfword table address wrong");
  chk_tbl_target: assert property (
    busy_q && mem_ack && !exc_entry && !exc_return && !mem_half_q
    |=> br_take_q && !busy_q && br_target_q == $past(next_q) + DW'({$past(mem_rdata[7:0]), 1'b0}))
    else $error("table jump target wrong");
  chk_pred_clear: assert property (
    fire && pred_q.live == 4'h1 && ins_kind == cbt_pkg::KIND_OTHER
    |=> pred_q.live == 4'h0 ##1 !in_blk || $past(fire) || $past(exc_return))
    else $error("block not closed after last slot");

  cov_cb_taken: cover property (fire && ins_kind == cbt_pkg::KIND_ZERO ##1 br_take_q);
  cov_blk_full: cover property (pred_q.live == 4'hF ##[1:20] pred_q.live == 4'h0);
  cov_tbl_half: cover property (busy_q && mem_half_q && mem_ack ##1 br_take_q);
  cov_exc_mid:  cover property (in_blk && exc_entry ##[1:50] exc_return);

endmodule : cbt_ctrl_flow

// ===== tb/compare_branch_predication_table_jump_tb_top.sv
// Purpose: self-checking bench for the control-flow unit at its top ports
// Assumes: inputs change at the falling edge, outputs read one falling edge later
// Notes:   the bench plays fetch, register file, table memory and exception logic
`timescale 1ns/100ps
module compare_branch_predication_table_jump_tb_top;
  logic                  ref_clk;     // core clock, 100 ns
  logic                  nrst;        // sync reset, low
  logic                  ins_valid;   // instruction offered
  cbt_pkg::cbt_kind_type ins_kind;    // decoded class
  logic [31:0]           ins_pc;      // instruction address
  logic [6:0]            cb_offset;   // compare branch offset
  logic [3:0]            base_sel;    // base register number
  logic [31:0]           base_val;    // base value
  logic [31:0]           index_val;   // index value
  logic [3:0]            pfx_cond;    // prefix condition
  logic [2:0]            pfx_len;     // prefix slot count
  logic [2:0]            pfx_else;    // else letters
  logic [3:0]            flags_nzcv;  // flags
  logic                  mem_ack;     // table entry back
  logic [15:0]           mem_rdata;   // table entry
  logic                  exc_entry;   // exception taken
  logic                  exc_return;  // exception return
  cbt_pkg::cbt_pred_type exc_restore; // stacked state
  logic                  busy_q;      // stall
  logic                  ins_exec_q;  // executed pulse
  logic                  flags_keep_q;// flags untouched
  logic                  br_take_q;   // branch pulse
  logic [31:0]           br_target_q; // branch address
  logic                  mem_req_q;   // table read
  logic [31:0]           mem_addr_q;  // table address
  logic                  mem_half_q;  // halfword entry
  cbt_pkg::cbt_pred_type pred_q;      // live state
  cbt_pkg::cbt_pred_type exc_saved_q; // saved state
  int                    errors;      // mismatches
  int                    n_compared;  // comparisons

  cbt_ctrl_flow #(.DW(32)) cbt_ctrl_flow_inst (
    .ref_clk(ref_clk), .nrst(nrst), .ins_valid(ins_valid), .ins_kind(ins_kind),
    .ins_pc(ins_pc), .cb_offset(cb_offset), .base_sel(base_sel), .base_val(base_val),
    .index_val(index_val), .pfx_cond(pfx_cond), .pfx_len(pfx_len), .pfx_else(pfx_else),
    .flags_nzcv(flags_nzcv), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .exc_entry(exc_entry), .exc_return(exc_return), .exc_restore(exc_restore),
    .busy_q(busy_q), .ins_exec_q(ins_exec_q), .flags_keep_q(flags_keep_q),
    .br_take_q(br_take_q), .br_target_q(br_target_q), .mem_req_q(mem_req_q),
    .mem_addr_q(mem_addr_q), .mem_half_q(mem_half_q), .pred_q(pred_q),
    .exc_saved_q(exc_saved_q)
  );

  // free-running core clock
  always #50 ref_clk = ~ref_clk;

  // compare one value, four-state exact
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // offer one op at a falling edge; valid stays up so ops can run back to back
  task automatic issue(input cbt_pkg::cbt_kind_type k);
    ins_kind  = k;
    ins_valid = 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : issue

  // drop the offer and let one edge pass
  task automatic idle();
    ins_valid = 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : idle

  // load the flags and the prefix fields for the next block
  task automatic set_pfx(input logic [3:0] f, input logic [3:0] c, input logic [2:0] n,
                         input logic [2:0] e);
    flags_nzcv = f;
    pfx_cond   = c;
    pfx_len    = n;
    pfx_else   = e;
  endtask : set_pfx

  // both compare forms, zero at the far end and nonzero at the near end of the forward range
  task automatic t_cmp();
    ins_pc    = 32'h0000_2000;
    base_sel  = 4'h5;
    base_val  = 32'h0000_0000;
    cb_offset = 7'h7e;
    issue(cbt_pkg::KIND_ZERO);
    chk("zero take", 32'h0000_0001, {31'h0, br_take_q});
    chk("zero target", 32'h0000_2082, br_target_q);
    chk("zero keep", 32'h0000_0001, {31'h0, flags_keep_q});
    issue(cbt_pkg::KIND_NONZERO);
    chk("nz on zero", 32'h0000_0000, {31'h0, br_take_q});
    base_val  = 32'h0000_0005;
    cb_offset = 7'h00;
    issue(cbt_pkg::KIND_NONZERO);
    chk("nz take", 32'h0000_0001, {31'h0, br_take_q});
    chk("nz target", 32'h0000_2004, br_target_q);
    chk("nz keep", 32'h0000_0001, {31'h0, flags_keep_q});
    issue(cbt_pkg::KIND_ZERO);
    chk("zero on nz", 32'h0000_0000, {31'h0, br_take_q});
    idle();
    $display("test t_cmp done");
  endtask : t_cmp

  // three-slot block then, then, else with z set
  task automatic t_pfx();
    set_pfx(4'b0100, 4'h0, 3'd3, 3'b010);
    issue(cbt_pkg::KIND_PREFIX);
    chk("pfx state", 32'h0000_0047, {20'h0, pred_q});
    chk("pfx keep", 32'h0000_0001, {31'h0, flags_keep_q});
    issue(cbt_pkg::KIND_OTHER);
    chk("slot1 exec", 32'h0000_0001, {31'h0, ins_exec_q});
    chk("slot1 state", 32'h0000_0023, {20'h0, pred_q});
    issue(cbt_pkg::KIND_OTHER);
    chk("slot2 exec", 32'h0000_0001, {31'h0, ins_exec_q});
    issue(cbt_pkg::KIND_OTHER);
    chk("slot3 exec", 32'h0000_0000, {31'h0, ins_exec_q});
    chk("block clear", 32'h0000_0000, {20'h0, pred_q});
    idle();
    $display("test t_pfx done");
  endtask : t_pfx

  // always prefix with four slots and no flags set
  task automatic t_always();
    int i;
    set_pfx(4'b0000, 4'hE, 3'd4, 3'b000);
    issue(cbt_pkg::KIND_PREFIX);
    chk("always state", 32'h0000_0E0F, {20'h0, pred_q});
    for (i = 0; i < 4; i++)
    begin
      issue(cbt_pkg::KIND_OTHER);
      chk("always exec", 32'h0000_0001, {31'h0, ins_exec_q});
    end
    chk("always clear", 32'h0000_0000, {20'h0, pred_q});
    idle();
    $display("test t_always done");
  endtask : t_always

  // breakpoint under a failing condition still runs
  task automatic t_brk();
    set_pfx(4'b0000, 4'h0, 3'd1, 3'b000);
    issue(cbt_pkg::KIND_PREFIX);
    issue(cbt_pkg::KIND_BREAK);
    chk("brk exec", 32'h0000_0001, {31'h0, ins_exec_q});
    idle();
    $display("test t_brk done");
  endtask : t_brk

  // one table jump: request, answer, branch
  task automatic tbl(input cbt_pkg::cbt_kind_type k, input logic [3:0] bs,
                     input logic [31:0] bv, input logic [31:0] iv, input logic [15:0] rd,
                     input logic [31:0] exp_addr, input logic [31:0] exp_tgt);
    ins_pc    = 32'h0000_3000;
    base_sel  = bs;
    base_val  = bv;
    index_val = iv;
    issue(k);
    ins_valid = 1'b0;
    chk("tbl req", 32'h0000_0001, {31'h0, mem_req_q});
    chk("tbl busy", 32'h0000_0001, {31'h0, busy_q});
    chk("tbl addr", exp_addr, mem_addr_q);
    chk("tbl half", {31'h0, k == cbt_pkg::KIND_HALF}, {31'h0, mem_half_q});
    mem_ack   = 1'b1;
    mem_rdata = rd;
    @(posedge ref_clk);
    @(negedge ref_clk);
    mem_ack   = 1'b0;
    mem_rdata = 16'hA5A5;
    chk("tbl take", 32'h0000_0001, {31'h0, br_take_q});
    chk("tbl target", exp_tgt, br_target_q);
    chk("tbl keep", 32'h0000_0001, {31'h0, flags_keep_q});
    chk("tbl free", 32'h0000_0000, {30'h0, busy_q, mem_req_q});
  endtask : tbl

  // halfword, byte with high garbage, and pc-based byte table
  task automatic t_tbl();
    // base never stack pointer, plain index
    tbl(cbt_pkg::KIND_HALF, 4'h2, 32'h0000_1000, 32'h0000_0003, 16'h0123,
        32'h0000_1006, 32'h0000_324A);
    tbl(cbt_pkg::KIND_BYTE, 4'h2, 32'h0000_1000, 32'h0000_0005, 16'hAB55,
        32'h0000_1005, 32'h0000_30AE);
    tbl(cbt_pkg::KIND_BYTE, 4'hF, 32'h0000_0000, 32'h0000_0002, 16'h0010,
        32'h0000_3006, 32'h0000_3024);
    $display("test t_tbl done");
  endtask : t_tbl

  // table jump as last slot: a failing slot reads nothing, a passing one closes at ack
  task automatic t_tbl_blk();
    // pc writer only as last slot
    set_pfx(4'b0000, 4'h0, 3'd1, 3'b000);
    issue(cbt_pkg::KIND_PREFIX);
    issue(cbt_pkg::KIND_BYTE);
    chk("tbl skip", 32'h0000_0000, {29'h0, busy_q, mem_req_q, ins_exec_q});
    chk("tbl skip clear", 32'h0000_0000, {20'h0, pred_q});
    set_pfx(4'b0100, 4'h0, 3'd1, 3'b000);
    issue(cbt_pkg::KIND_PREFIX);
    tbl(cbt_pkg::KIND_BYTE, 4'h2, 32'h0000_1000, 32'h0000_0001, 16'h0003,
        32'h0000_1001, 32'h0000_300A);
    chk("tbl blk clear", 32'h0000_0000, {20'h0, pred_q});
    $display("test t_tbl_blk done");
  endtask : t_tbl_blk

  // exception between prefix and block, return resumes the block
  task automatic t_exc();
    set_pfx(4'b0000, 4'h0, 3'd2, 3'b001);
    issue(cbt_pkg::KIND_PREFIX);
    ins_valid = 1'b0;
    exc_entry = 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    exc_entry = 1'b0;
    chk("exc saved", 32'h0000_0023, {20'h0, exc_saved_q});
    chk("exc clear", 32'h0000_0000, {20'h0, pred_q});
    exc_return  = 1'b1;
    exc_restore = 12'h023;
    @(posedge ref_clk);
    @(negedge ref_clk);
    exc_return  = 1'b0;
    exc_restore = 12'h000;
    chk("ret state", 32'h0000_0023, {20'h0, pred_q});
    issue(cbt_pkg::KIND_OTHER);
    chk("ret slot1", 32'h0000_0000, {31'h0, ins_exec_q});
    issue(cbt_pkg::KIND_OTHER);
    chk("ret slot2", 32'h0000_0001, {31'h0, ins_exec_q});
    chk("ret clear", 32'h0000_0000, {20'h0, pred_q});
    idle();
    $display("test t_exc done");
  endtask : t_exc

  // verdict and end of run, reached from the main sequence or the watchdog
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  // whole run is well under a hundred cycles; allow twenty times that
  initial
  begin
    #200000;
    errors++;
    results();
  end

  // main sequence: reset two cycles, then every scenario
  initial
  begin
    ref_clk     = 1'b0;
    nrst        = 1'b0;
    ins_valid   = 1'b0;
    ins_kind    = cbt_pkg::KIND_OTHER;
    ins_pc      = 32'h0000_0000;
    cb_offset   = 7'h00;
    base_sel    = 4'h0;
    base_val    = 32'h0000_0000;
    index_val   = 32'h0000_0000;
    set_pfx(4'h0, 4'h0, 3'd1, 3'b000);
    mem_ack     = 1'b0;
    mem_rdata   = 16'h0000;
    exc_entry   = 1'b0;
    exc_return  = 1'b0;
    exc_restore = 12'h000;
    errors      = 0;
    n_compared  = 0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk("reset state", 32'h0000_0000, {20'h0, pred_q});
    t_cmp();
    t_pfx();
    t_always();
    t_brk();
    t_tbl();
    t_tbl_blk();
    t_exc();
    results();
  end
endmodule : compare_branch_predication_table_jump_tb_top
